// ---- sqr_master_model.sv ----
// Upstream master model: raises address valid per port and retires accepted transactions.
`default_nettype none
module sqr_master_model
(
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic [4:0]      i_go,
  input  wire logic            i_free,
  input  wire logic [4:0]      i_ready,
  output logic      [4:0]      o_valid,
  output logic      [4:0]      o_done,
  output logic      [4:0][7:0] o_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Valid is held until accepted; completions never outrun issued transactions.
  always_ff @(posedge i_clk)
  begin
    for (int p = 0; p < 5; p++)
    begin
      if (i_rst)
      begin
        o_valid[p] <= 1'b0;
        o_done[p]  <= 1'b0;
        o_cnt[p]   <= 8'h00;
      end
      else
      begin
        o_valid[p] <= i_go[p] | (o_valid[p] & ~i_ready[p]);
        o_cnt[p]   <= o_cnt[p] + 8'(o_valid[p] & i_ready[p]) - 8'(o_done[p]);
        o_done[p]  <= i_free & (o_cnt[p] > 8'(o_done[p]));
      end
    end
  end
endmodule : sqr_master_model
`default_nettype wire

// ---- sqr_ot_limiter.sv ----
// Outstanding-transaction limiter for one address channel of one slave port.
`default_nettype none
module sqr_ot_limiter
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_enable,
  input  wire logic [sqr_pkg::OT_W-1:0]   i_int,
  input  wire logic [sqr_pkg::FRAC_W-1:0] i_frac,
  input  wire logic [sqr_pkg::OT_W-1:0]   i_max,
  input  wire logic                      i_accept,
  input  wire logic                      i_done,
  output logic                           o_allow,
  output logic [sqr_pkg::OT_W-1:0]        o_count
);
  import sqr_pkg::*;

  logic [OT_W-1:0] count_reg, count_next;
  logic            active_reg, active_next;
  logic [FRAC_W-1:0] acc_reg, acc_next;
  logic            credit_reg, credit_next;
  logic [OT_W-1:0] lim;
  logic [FRAC_W:0] acc_sum;
  logic            at_lim;

  // ==========================================================================
  // Limit selection and acceptance
  always_comb
  begin
    if (i_int == '0 && i_frac == '0)
      lim = i_max;
    else if (i_int > i_max)
      lim = i_max;
    else
      lim = i_int;
    at_lim  = (count_reg == lim) && (lim < i_max);
    acc_sum = {1'b0, acc_reg} + {1'b0, i_frac};
    if (!active_reg)
      o_allow = (count_reg < i_max);
    else
      o_allow = (count_reg < lim) || (at_lim && i_frac != '0 && credit_reg);
    count_next  = count_reg + OT_W'(i_accept) - OT_W'(i_done);
    active_next = (count_reg == '0) ? i_enable : active_reg;
    acc_next    = (active_reg && i_frac != '0) ? acc_sum[FRAC_W-1:0] : '0;
    // A new carry wins over consumption of the previous credit.
    credit_next = (active_reg && i_frac != '0 && acc_sum[FRAC_W]) ||
                  (credit_reg && !(i_accept && count_reg >= lim) && i_frac != '0);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      count_reg  <= '0;
      active_reg <= 1'b0;
      acc_reg    <= '0;
      credit_reg <= 1'b0;
    end
    else
    begin
      count_reg  <= count_next;
      active_reg <= active_next;
      acc_reg    <= acc_next;
      credit_reg <= credit_next;
    end
  end

  assign o_count = count_reg;

  // ==========================================================================
  // Checks
  property p_lim_switch;
    @(posedge i_clk) disable iff (i_rst)
    (active_reg != $past(active_reg)) |-> ($past(count_reg) == '0);
  endproperty
  a_lim_switch: assert property (p_lim_switch) else $error("limit mode changed with traffic");

endmodule : sqr_ot_limiter
`default_nettype wire

// ---- sqr_pkg.sv ----
// Package of constants, register map and shared types of the slave port QoS regulator.
`default_nettype none
package sqr_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPORT  = 5;
  localparam int NLITE  = 3;
  localparam int OT_W   = 6;
  localparam int TGT_W  = 12;
  localparam int SCL_W  = 3;
  localparam int INTG_W = 16;
  localparam int QOS_W  = 4;
  localparam int FRAC_W = 8;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_SECURE = 12'h004;
  localparam logic [11:0] OFS_LIMIT  = 12'h100;
  localparam logic [11:0] OFS_TARGET = 12'h200;
  localparam logic [11:0] OFS_SCALE  = 12'h300;

  // ==========================================================================
  // Field positions
  localparam int RD_INT_LSB  = 24;
  localparam int RD_FRAC_LSB = 16;
  localparam int WR_INT_LSB  = 8;
  localparam int WR_FRAC_LSB = 0;
  localparam int RD_TGT_LSB  = 16;
  localparam int WR_TGT_LSB  = 0;
  localparam int RD_SCL_LSB  = 8;
  localparam int WR_SCL_LSB  = 0;
  localparam int CTRL_RD_MODE = 20;
  localparam int CTRL_WR_MODE = 16;
  localparam int CTRL_RD_OT   = 3;
  localparam int CTRL_WR_OT   = 2;
  localparam int CTRL_RD_QV   = 1;
  localparam int CTRL_WR_QV   = 0;
  localparam int SEC_NS_OK    = 0;

  // ==========================================================================
  // Writable bit masks and reset values
  localparam logic [31:0] LIMIT_MASK  = 32'h3fff_3fff;
  localparam logic [31:0] TARGET_MASK = 32'h0fff_0fff;
  localparam logic [31:0] SCALE_MASK  = 32'h0000_0707;
  localparam logic [31:0] CTRL_MASK   = 32'h0011_000f;
  localparam logic [31:0] SECURE_MASK = 32'h0000_0001;
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;

  // ==========================================================================
  // Synthesis-time outstanding maxima, scale base and fraction denominator
  localparam logic [OT_W-1:0] OT_MAX_RD  = 6'h20;
  localparam logic [OT_W-1:0] OT_MAX_WR  = 6'h20;
  localparam logic [3:0]      SCALE_BASE = 4'h5;
  localparam int              FRAC_DEN   = 256;

  typedef enum {SQR_APB_IDLE, SQR_APB_RESP} sqr_apb_state_t;

  // Returns high when a byte address lands on an implemented register.
  function automatic logic sqr_map_hit(input logic [11:0] addr);
    logic [2:0] idx;
    idx = addr[4:2];
    sqr_map_hit = 1'b0;
    if (addr[7:5] == 3'h0 && addr[1:0] == 2'h0)
    begin
      unique case (addr[11:8])
        4'h0: sqr_map_hit = (addr == OFS_CTRL) || (addr == OFS_SECURE);
        4'h1: sqr_map_hit = (idx < 3'(NLITE));
        4'h2, 4'h3: sqr_map_hit = (idx < 3'(NPORT));
        default: sqr_map_hit = 1'b0;
      endcase
    end
  endfunction : sqr_map_hit

endpackage : sqr_pkg
`default_nettype wire

// ---- sqr_qv_regulator.sv ----
// QoS value regulator with a 16-bit integrator for one direction of one slave port.
`default_nettype none
module sqr_qv_regulator
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_enable,
  input  wire logic                      i_select,
  input  wire logic                      i_period_mode,
  input  wire logic [sqr_pkg::TGT_W-1:0]  i_target,
  input  wire logic [sqr_pkg::SCL_W-1:0]  i_scale,
  input  wire logic                      i_issue,
  input  wire logic                      i_complete,
  input  wire logic [sqr_pkg::OT_W-1:0]   i_outstanding,
  output logic [sqr_pkg::QOS_W-1:0]       o_qos
);
  import sqr_pkg::*;

  logic [INTG_W-1:0] intg_reg, intg_next;
  logic [QOS_W-1:0]  qos_reg, qos_next;
  logic              run;
  logic [INTG_W+1:0] sum;
  logic [INTG_W-1:0] scaled;
  logic [3:0]        shamt;

  // ==========================================================================
  // Integrator and scaling
  always_comb
  begin
    run   = i_enable && i_select && (i_target != '0);
    shamt = SCALE_BASE + {1'b0, i_scale};
    // Period mode counts cycles against issues, latency mode sums wait time.
    if (i_period_mode)
      sum = {2'b0, intg_reg} + 18'h1 - (i_issue ? {6'h0, i_target} : 18'h0);
    else
      sum = {2'b0, intg_reg} + {12'h0, i_outstanding} -
            (i_complete ? {6'h0, i_target} : 18'h0);
    if (!run || sum[INTG_W+1])
      intg_next = '0;
    else if (sum[INTG_W])
      intg_next = '1;
    else
      intg_next = sum[INTG_W-1:0];
    scaled   = intg_reg >> shamt;
    if (!run)
      qos_next = '0;
    else if (scaled > INTG_W'(4'hf))
      qos_next = 4'hf;
    else
      qos_next = scaled[QOS_W-1:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      intg_reg <= '0;
      qos_reg  <= '0;
    end
    else
    begin
      intg_reg <= intg_next;
      qos_reg  <= qos_next;
    end
  end

  assign o_qos = qos_reg;

endmodule : sqr_qv_regulator
`default_nettype wire

// ---- sqr_regulator.sv ----
// Slave port QoS regulator top: APB register file, limiters and QoS value regulators.
// Function
// - One outstanding limit register per lite port, none for full ports.
// - Zero integer and fraction means hardware limits apply on that channel.
// - Zero fraction regulates whole transactions only, no fractional averaging.
// - Mean outstanding count stays at or below integer plus fraction over 256.
// - Limits above the built-in maximum have no effect; maximum never exceeded.
// - Register accesses need secure transactions unless non-secure access is allowed; the secure-access register always needs them.
// - Read limit: integer bits 29 to 24, fraction bits 23 to 16, reset zero.
// - Write limit: integer bits 13 to 8, fraction bits 7 to 0, reset zero.
// - Target counts clock cycles: latency or period as the mode selects.
// - Target zero disables QoS value regulation for that channel.
// - Per port read target bits 27 to 16, write target bits 11 to 0.
// - Target and scale act only while the port's select input is high.
// - Per port read scale bits 10 to 8, write scale bits 2 to 0.
// - Scale value n selects multiplier two to the minus (five plus n).
// - A 16-bit integrator scaled by that factor gives the QoS value.
// - Target and scale registers exist for every port including full ports.
// - Mode bit 20 for reads, 16 for writes: zero latency, one period.
// - Limit enables bit 3 reads, bit 2 writes, lite ports only.
// - Limit enable changes take effect only with nothing outstanding.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`default_nettype none
module sqr_regulator
(
  input  wire logic                                i_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_psel,
  input  wire logic                                i_penable,
  input  wire logic                                i_pwrite,
  input  wire logic [11:0]                         i_paddr,
  input  wire logic [31:0]                         i_pwdata,
  input  wire logic [2:0]                          i_pprot,
  output logic [31:0]                              o_prdata,
  output logic                                     o_pready,
  output logic                                     o_pslverr,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_qos_regulation_select,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_ar_valid,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_ar_dn_ready,
  output logic      [sqr_pkg::NPORT-1:0]           o_ar_ready,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_rd_done,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_aw_valid,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_aw_dn_ready,
  output logic      [sqr_pkg::NPORT-1:0]           o_aw_ready,
  input  wire logic [sqr_pkg::NPORT-1:0]           i_wr_done,
  output logic      [sqr_pkg::NPORT-1:0][sqr_pkg::QOS_W-1:0] o_arqos,
  output logic      [sqr_pkg::NPORT-1:0][sqr_pkg::QOS_W-1:0] o_awqos
);
  import sqr_pkg::*;

  // ==========================================================================
  // Register state
  sqr_apb_state_t state_reg, state_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] secure_reg, secure_next;
  logic [31:0] limit_reg [NLITE];
  logic [31:0] limit_next [NLITE];
  logic [31:0] target_reg [NPORT];
  logic [31:0] target_next [NPORT];
  logic [31:0] scale_reg [NPORT];
  logic [31:0] scale_next [NPORT];
  logic [31:0] prdata_reg, prdata_next;
  logic        pslverr_reg, pslverr_next;
  logic        access_ok;
  logic        hit;
  logic        wr_fire;
  logic [2:0]  idx;
  logic [31:0] rd_val;

  logic [NPORT-1:0] ar_allow, aw_allow;
  logic [NPORT-1:0][OT_W-1:0] ar_count, aw_count;

  // ==========================================================================
  // APB slave: one wait state, errors for unmapped or refused accesses
  always_comb
  begin
    idx       = i_paddr[4:2];
    hit       = sqr_map_hit(i_paddr);
    // The secure-access register itself is only ever reachable securely.
    access_ok = !i_pprot[1] || (secure_reg[SEC_NS_OK] && i_paddr != OFS_SECURE);
    wr_fire   = (state_reg == SQR_APB_RESP) && i_psel && i_penable && i_pwrite &&
                !pslverr_reg;
    rd_val = '0;
    unique case (i_paddr[11:8])
      4'h0: rd_val = (i_paddr == OFS_CTRL) ? ctrl_reg : secure_reg;
      4'h1: rd_val = (idx < 3'(NLITE)) ? limit_reg[idx[1:0]] : '0;
      4'h2: rd_val = (idx < 3'(NPORT)) ? target_reg[idx] : '0;
      4'h3: rd_val = (idx < 3'(NPORT)) ? scale_reg[idx] : '0;
      default: rd_val = '0;
    endcase
    state_next   = state_reg;
    prdata_next  = prdata_reg;
    pslverr_next = pslverr_reg;
    unique case (state_reg)
      SQR_APB_IDLE:
      begin
        if (i_psel && i_penable)
        begin
          state_next   = SQR_APB_RESP;
          pslverr_next = !hit || !access_ok;
          prdata_next  = (hit && access_ok && !i_pwrite) ? rd_val : '0;
        end
      end
      SQR_APB_RESP:
      begin
        state_next   = SQR_APB_IDLE;
        pslverr_next = 1'b0;
        prdata_next  = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg   <= SQR_APB_IDLE;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign o_pready  = (state_reg == SQR_APB_RESP);
  assign o_pslverr = pslverr_reg && o_pready;
  assign o_prdata  = prdata_reg;

  // ==========================================================================
  // Register writes, masked so reserved bits stay zero
  always_comb
  begin
    ctrl_next   = ctrl_reg;
    secure_next = secure_reg;
    limit_next  = limit_reg;
    target_next = target_reg;
    scale_next  = scale_reg;
    if (wr_fire)
    begin
      unique case (i_paddr[11:8])
        4'h0:
        begin
          if (i_paddr == OFS_CTRL)
            ctrl_next = i_pwdata & CTRL_MASK;
          else
            secure_next = i_pwdata & SECURE_MASK;
        end
        4'h1: limit_next[idx[1:0]] = i_pwdata & LIMIT_MASK;
        4'h2: target_next[idx] = i_pwdata & TARGET_MASK;
        4'h3: scale_next[idx] = i_pwdata & SCALE_MASK;
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctrl_reg   <= REG_RESET;
      secure_reg <= REG_RESET;
      for (int i = 0; i < NLITE; i++)
        limit_reg[i] <= REG_RESET;
      for (int i = 0; i < NPORT; i++)
      begin
        target_reg[i] <= REG_RESET;
        scale_reg[i]  <= REG_RESET;
      end
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      secure_reg  <= secure_next;
      limit_reg   <= limit_next;
      target_reg  <= target_next;
      scale_reg   <= scale_next;
    end
  end

  // ==========================================================================
  // Per-port limiters and regulators
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic               ar_en, aw_en;
    logic [OT_W-1:0]    ar_int, aw_int;
    logic [FRAC_W-1:0]  ar_frac, aw_frac;
    if (p < NLITE)
    begin : g_lite
      assign ar_en   = ctrl_reg[CTRL_RD_OT];
      assign aw_en   = ctrl_reg[CTRL_WR_OT];
      assign ar_int  = limit_reg[p][RD_INT_LSB +: OT_W];
      assign ar_frac = limit_reg[p][RD_FRAC_LSB +: FRAC_W];
      assign aw_int  = limit_reg[p][WR_INT_LSB +: OT_W];
      assign aw_frac = limit_reg[p][WR_FRAC_LSB +: FRAC_W];
    end
    else
    begin : g_full
      assign ar_en   = 1'b0;
      assign aw_en   = 1'b0;
      assign ar_int  = '0;
      assign ar_frac = '0;
      assign aw_int  = '0;
      assign aw_frac = '0;
    end

    assign o_ar_ready[p] = i_ar_dn_ready[p] && ar_allow[p];
    assign o_aw_ready[p] = i_aw_dn_ready[p] && aw_allow[p];

    sqr_ot_limiter u_ar_lim (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_enable (ar_en),
      .i_int    (ar_int),
      .i_frac   (ar_frac),
      .i_max    (OT_MAX_RD),
      .i_accept (i_ar_valid[p] && o_ar_ready[p]),
      .i_done   (i_rd_done[p]),
      .o_allow  (ar_allow[p]),
      .o_count  (ar_count[p])
    );

    sqr_ot_limiter u_aw_lim (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_enable (aw_en),
      .i_int    (aw_int),
      .i_frac   (aw_frac),
      .i_max    (OT_MAX_WR),
      .i_accept (i_aw_valid[p] && o_aw_ready[p]),
      .i_done   (i_wr_done[p]),
      .o_allow  (aw_allow[p]),
      .o_count  (aw_count[p])
    );

    sqr_qv_regulator u_ar_qv (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_enable      (ctrl_reg[CTRL_RD_QV]),
      .i_select      (i_qos_regulation_select[p]),
      .i_period_mode (ctrl_reg[CTRL_RD_MODE]),
      .i_target      (target_reg[p][RD_TGT_LSB +: TGT_W]),
      .i_scale       (scale_reg[p][RD_SCL_LSB +: SCL_W]),
      .i_issue       (i_ar_valid[p] && o_ar_ready[p]),
      .i_complete    (i_rd_done[p]),
      .i_outstanding (ar_count[p]),
      .o_qos         (o_arqos[p])
    );

    sqr_qv_regulator u_aw_qv (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_enable      (ctrl_reg[CTRL_WR_QV]),
      .i_select      (i_qos_regulation_select[p]),
      .i_period_mode (ctrl_reg[CTRL_WR_MODE]),
      .i_target      (target_reg[p][WR_TGT_LSB +: TGT_W]),
      .i_scale       (scale_reg[p][WR_SCL_LSB +: SCL_W]),
      .i_issue       (i_aw_valid[p] && o_aw_ready[p]),
      .i_complete    (i_wr_done[p]),
      .i_outstanding (aw_count[p]),
      .o_qos         (o_awqos[p])
    );
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_ns_refused;
    (i_psel && i_penable && i_pprot[1] && !secure_reg[SEC_NS_OK] && state_reg == SQR_APB_IDLE)
      |=> (o_pready && o_pslverr);
  endproperty
  a_ns_refused: assert property (p_ns_refused) else $error("non-secure access accepted");

  property p_limit_write;
    (wr_fire && i_paddr == OFS_LIMIT)
      |=> (limit_reg[0][RD_INT_LSB +: OT_W] == $past(i_pwdata[29:24]) &&
           limit_reg[0][WR_FRAC_LSB +: FRAC_W] == $past(i_pwdata[7:0]));
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("limit fields misplaced");

  property p_limit_wr_int;
    (wr_fire && i_paddr == OFS_LIMIT)
      |=> (limit_reg[0][WR_INT_LSB +: OT_W] == $past(i_pwdata[13:8]));
  endproperty
  a_limit_wr_int: assert property (p_limit_wr_int) else $error("write integer misplaced");

  property p_scale_rsvd;
    (o_pready && !o_pslverr && !i_pwrite && i_paddr[11:8] == 4'h3)
      |-> (o_prdata[31:11] == '0 && o_prdata[7:3] == '0);
  endproperty
  a_scale_rsvd: assert property (p_scale_rsvd) else $error("reserved bits read nonzero");

  property p_full_free;
    (o_ar_ready[3] == i_ar_dn_ready[3]) || (ar_count[3] == OT_MAX_RD);
  endproperty
  a_full_free: assert property (p_full_free) else $error("full port limited");

  property p_max_bound;
    (ar_count[0] == OT_MAX_RD) |-> !o_ar_ready[0];
  endproperty
  a_max_bound: assert property (p_max_bound) else $error("read maximum exceeded");

  property p_sel_low;
    (!i_qos_regulation_select[1])[*2] |-> (o_arqos[1] == '0 && o_awqos[1] == '0);
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("QoS issued without select");

  property p_tgt_zero;
    (target_reg[2][RD_TGT_LSB +: TGT_W] == '0)[*2] |-> (o_arqos[2] == '0);
  endproperty
  a_tgt_zero: assert property (p_tgt_zero) else $error("QoS with zero target");

  property p_whole_only;
    (g_port[0].u_ar_lim.active_reg && limit_reg[0][RD_FRAC_LSB +: FRAC_W] == '0 &&
     limit_reg[0][RD_INT_LSB +: OT_W] != '0 && ar_count[0] >= limit_reg[0][RD_INT_LSB +: OT_W])
      |-> !ar_allow[0];
  endproperty
  a_whole_only: assert property (p_whole_only) else $error("fractional excess allowed");

  c_write_limit: cover property (wr_fire && i_paddr[11:8] == 4'h1);
  c_stall:       cover property (i_ar_valid[0] && i_ar_dn_ready[0] && !o_ar_ready[0]);
  c_qos_up:      cover property (o_arqos[3] != '0);
  c_slverr:      cover property (o_pready && o_pslverr);

endmodule : sqr_regulator
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench of the slave port QoS regulator.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic             clk, rst, psel, penable, pwrite, pready, pslverr, free, e;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [2:0]       pprot;
  logic [4:0]       sel, go, valid, done, arrdy, awrdy, dnr;
  logic [4:0][7:0]  cnt;
  logic [4:0][3:0]  arq, awq;
  int               miscompares, n_compared;

  localparam logic [11:0] ra [5] = '{12'h100, 12'h10c, 12'h210, 12'h310, 12'h000};
  localparam logic [31:0] rx [5] = '{32'h3fff_3fff, 32'h0, 32'h0fff_0fff,
                                     32'h0000_0707, 32'h0011_000f};

  sqr_regulator u_sqr_regulator (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pprot(pprot), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_qos_regulation_select(sel), .i_ar_valid(valid), .i_ar_dn_ready(dnr),
    .o_ar_ready(arrdy), .i_rd_done(done), .i_aw_valid(5'h00), .i_aw_dn_ready(dnr),
    .o_aw_ready(awrdy), .i_wr_done(5'h00), .o_arqos(arq), .o_awqos(awq));

  sqr_master_model u_sqr_master_model (.i_clk(clk), .i_rst(rst), .i_go(go),
    .i_free(free), .i_ready(arrdy), .o_valid(valid), .o_done(done), .o_cnt(cnt));

  // ==========================================================================
  // Clock, watchdog and shared tasks
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done();
  end

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen high at a rising edge.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] p, output logic [31:0] r, output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= p;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst, psel, penable, pwrite, free} = 5'h10;
    {paddr, pwdata, pprot, sel, go} = '0;
    dnr = 5'h1f;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      apb(ra[i], 1'b0, 32'h0, 3'h0, rd, e);
      chk(rd, 32'h0);
      apb(ra[i], 1'b1, 32'hffff_ffff, 3'h0, rd, e);
      apb(ra[i], 1'b0, 32'h0, 3'h0, rd, e);
      chk(rd, rx[i]);
      chk({31'h0, e}, {31'h0, rx[i] == 32'h0});
    end
    $display("register map test done");
    apb(12'h204, 1'b1, 32'h1, 3'h2, rd, e);
    chk({31'h0, e}, 32'h1);
    apb(12'h204, 1'b0, 32'h0, 3'h0, rd, e);
    chk(rd, 32'h0);
    apb(12'h004, 1'b1, 32'h1, 3'h0, rd, e);
    apb(12'h210, 1'b0, 32'h0, 3'h2, rd, e);
    chk(rd, 32'h0fff_0fff);
    apb(12'h004, 1'b1, 32'h0, 3'h0, rd, e);
    $display("secure access test done");
    apb(12'h000, 1'b1, 32'h8, 3'h0, rd, e);
    apb(12'h100, 1'b1, 32'h0200_0000, 3'h0, rd, e);
    apb(12'h104, 1'b1, 32'h0, 3'h0, rd, e);
    apb(12'h108, 1'b1, 32'h3f00_0000, 3'h0, rd, e);
    go <= 5'h07;
    repeat (60) @(posedge clk);
    chk({24'h0, cnt[0]}, 32'h2);
    chk({24'h0, cnt[1]}, 32'h20);
    chk({24'h0, cnt[2]}, 32'h20);
    chk({27'h0, awrdy}, 32'h1f);
    go <= 5'h00;
    free <= 1'b1;
    repeat (80) @(posedge clk);
    $display("outstanding limit test done");
    apb(12'h000, 1'b1, 32'h0010_0003, 3'h0, rd, e);
    apb(12'h20c, 1'b1, 32'h0064_0064, 3'h0, rd, e);
    apb(12'h30c, 1'b1, 32'h0000_0700, 3'h0, rd, e);
    sel <= 5'h08;
    repeat (600) @(posedge clk);
    chk({28'h0, arq[3]}, 32'h0);
    apb(12'h30c, 1'b1, 32'h0, 3'h0, rd, e);
    repeat (3) @(posedge clk);
    chk({28'h0, arq[3]}, 32'hf);
    chk({28'h0, awq[3]}, 32'h0);
    sel <= 5'h00;
    repeat (3) @(posedge clk);
    chk({28'h0, arq[3]}, 32'h0);
    apb(12'h20c, 1'b1, 32'h0, 3'h0, rd, e);
    sel <= 5'h08;
    repeat (40) @(posedge clk);
    chk({28'h0, arq[3]}, 32'h0);
    $display("qos value test done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(12'h100, 1'b0, 32'h0, 3'h0, rd, e);
    chk(rd, 32'h0);
    chk({31'h0, e}, 32'h0);
    apb(12'h000, 1'b0, 32'h0, 3'h0, rd, e);
    chk(rd, 32'h0);
    $display("reset test done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
